// ### design/srtap_pkg.sv
/*
  Constants, instruction codes and controller state type for the SRAM test
  access port instruction logic.
  Assumes a single core clock that oversamples the test clock pins.
*/
// Summary of operation
// - three-bit instruction register; all eight codes decoded, three of them reserved.
// - no path into the memory core; no preload of output buffers.
// - test-style instructions only capture the I/O ring; pins never driven from scan.
// - in Shift-IR the instruction register sits between TDI and TDO, one bit per rise.
// - a shifted instruction applies only at Update-IR.
// - all-zero code is the external-test instruction, not unimplemented.
// - external test behaves as sample/preload but forces SRAM outputs to high impedance.
// - identification captures a fixed 32-bit code in Capture-DR, shifts it in Shift-DR.
// - identification is the current instruction at power-up and in test-logic-reset.
// - sample-with-high-impedance puts the boundary register on the path in Shift-DR.
// - sample-with-high-impedance forces every SRAM output to high impedance.
// - sample/preload Capture-DR snapshots all input and bidirectional pins.
// - sample/preload Shift-DR shifts the captured boundary values out.
// - sample/preload Update-DR does nothing more than Pause-DR.
// - bypass puts the one-bit bypass register on the path in Shift-DR.
// - codes 000 ext, 001 id, 010 sample-z, 100 sample, 111 bypass; rest reserved.
// - Capture-IR loads the two low instruction bits with 01.
// - five rising TCK edges with TMS high reset the test logic.
// - scan registers take TDI at MSB, give LSB on TDO; TDO changes on falling TCK.
`default_nettype none

package srtap_pkg;

  // ==========================================================================
  // scan register sizes
  localparam int IR_WIDTH   = 3;
  localparam int ID_WIDTH   = 32;
  localparam int BSR_WIDTH  = 73;

  // ==========================================================================
  // instruction codes
  localparam logic [2:0] INSTR_EXTEST   = 3'h0;
  localparam logic [2:0] INSTR_IDCODE   = 3'h1;
  localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INSTR_SAMPLE   = 3'h4;
  localparam logic [2:0] INSTR_BYPASS   = 3'h7;

  // capture pattern of the instruction register, low bits 01
  localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;
  // bypass register captures low
  localparam logic       BYPASS_CAP_VAL = 1'b0;
  // test-logic-reset after this many rises with TMS high
  localparam int         RESET_TMS_RISES = 5;

  // ==========================================================================
  // timing: fastest test clock against the core clock
  localparam int CORE_PERIOD_NS    = 25;
  localparam int TCK_MIN_PERIOD_NS = 100;
  // cycles of core clock per fastest test clock period, rounded down
  localparam int TCK_MIN_CYCLES    = TCK_MIN_PERIOD_NS / CORE_PERIOD_NS;
  // synchroniser plus edge detector needs this many samples per period
  localparam int TCK_NEED_CYCLES   = 4;

  // ==========================================================================
  // controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } srtap_state_type;

endpackage : srtap_pkg

`default_nettype wire

// ### design/srtap_scan_reg.sv
/*
  Parallel-capture, serial-shift scan register.
  Assumes capture and shift strobes are one-cycle enables and never coincide.
*/
`timescale 1ns/1ps
`default_nettype none

module srtap_scan_reg
  import srtap_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire  logic             clk,
  input  wire  logic             rst,
  // strobes
  input  wire  logic             capture_en,
  input  wire  logic             shift_en,
  // data
  input  wire  logic [WIDTH-1:0] cap_val,
  input  wire  logic             scan_in,
  output logic       [WIDTH-1:0] data
);

  logic [WIDTH-1:0] data_q;
  logic [WIDTH-1:0] data_d;

  // ==========================================================================
  // elaboration check
  if (WIDTH < 1) begin : g_bad_width
    $error("srtap_scan_reg: WIDTH must be at least one");
  end

  // scan-in lands in the MSB, LSB leaves toward TDO
  if (WIDTH == 1) begin : g_one
    assign data_d = capture_en ? cap_val : (shift_en ? scan_in : data_q);
  end else begin : g_many
    assign data_d = capture_en ? cap_val :
                    (shift_en ? {scan_in, data_q[WIDTH-1:1]} : data_q);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q <= '0;
    end else begin
      data_q <= data_d;
    end
  end

  assign data = data_q;

endmodule // srtap_scan_reg

`default_nettype wire

// ### design/srtap_sync.sv
/*
  Two-flop synchroniser for a bundle of independent level signals.
  Assumes each bit is a slow level; no bus coherence is given across bits.
*/
`timescale 1ns/1ps
`default_nettype none

module srtap_sync
  import srtap_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire  logic             clk,
  input  wire  logic             rst,
  // asynchronous in, synchronised out
  input  wire  logic [WIDTH-1:0] async_in,
  output logic       [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ==========================================================================
  // elaboration check
  if (WIDTH < 1) begin : g_bad_width
    $error("srtap_sync: WIDTH must be at least one");
  end

  // first flop feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // srtap_sync

`default_nettype wire

// ### design/srtap_top.sv
/*
  Test access port instruction logic of a synchronous SRAM: controller state,
  instruction register, data register selection, TDO drive and output high-Z.
  Assumes TCK, TMS, TDI and the I/O ring arrive asynchronously and that TCK
  runs at most a quarter of core_clk; all pins pass two flops first.
*/
`timescale 1ns/1ps
`default_nettype none

module srtap_top
  import srtap_pkg::*;
#(
  parameter int          BSR_W   = BSR_WIDTH,
  // arbitrary identification value, bit 0 kept high as presence marker
  parameter logic [31:0] ID_CODE = 32'h1234_5679
) (
  // clock and reset
  input  wire  logic             core_clk,
  input  wire  logic             rst,
  // test pins
  input  wire  logic             tck,
  input  wire  logic             tms,
  input  wire  logic             tdi,
  output logic                   tdo_out,
  output logic                   tdo_oe,
  // I/O ring sampled by the boundary register
  input  wire  logic [BSR_W-1:0] io_ring,
  // high-impedance request to all SRAM output drivers
  output logic                   sram_out_hiz
);

  // ==========================================================================
  // elaboration checks
  if (BSR_W < 2) begin : g_bad_bsr
    $error("srtap_top: BSR_W must be at least two");
  end
  if (TCK_MIN_CYCLES < TCK_NEED_CYCLES) begin : g_bad_rate
    $error("srtap_top: core clock too slow to oversample the test clock");
  end

  // ==========================================================================
  // pin synchronisers
  logic [2:0]       pins_s;
  logic [BSR_W-1:0] ring_s;
  logic             tck_s;
  logic             tms_s;
  logic             tdi_s;
  logic             tck_prev_q;

  srtap_sync #(.WIDTH(3)) u_pin_sync (
    .clk      (core_clk),
    .rst      (rst),
    .async_in ({tck, tms, tdi}),
    .sync_out (pins_s)
  );

  // ring values change at SRAM speed; a capture may still land mid-transition
  srtap_sync #(.WIDTH(BSR_W)) u_ring_sync (
    .clk      (core_clk),
    .rst      (rst),
    .async_in (io_ring),
    .sync_out (ring_s)
  );

  assign tck_s = pins_s[2];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[0];

  // edge finder on the synchronised test clock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
    end
  end

  logic tck_rise;
  logic tck_fall;
  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;

  // ==========================================================================
  // controller state machine
  srtap_state_type state_q;
  srtap_state_type state_d;
  srtap_state_type state_nx;

  function automatic srtap_state_type next_state(input srtap_state_type s, input logic m);
    unique case (s)
      ST_RESET:    next_state = m ? ST_RESET    : ST_IDLE;
      ST_IDLE:     next_state = m ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   next_state = m ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = m ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = m ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   next_state = m ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = m ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = m ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
      default:     next_state = ST_RESET;
    endcase
  endfunction

  // any state reaches reset after five rises with TMS high
  assign state_nx = next_state(state_q, tms_s);
  assign state_d  = tck_rise ? state_nx : state_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // one-cycle strobes per controller action
  logic cap_ir_en;
  logic shift_ir_en;
  logic upd_ir_en;
  logic cap_dr_en;
  logic shift_dr_en;
  assign cap_ir_en   = tck_rise & (state_q == ST_CAP_IR);
  assign shift_ir_en = tck_rise & (state_q == ST_SHIFT_IR);
  assign upd_ir_en   = tck_rise & (state_q == ST_UPD_IR);
  assign cap_dr_en   = tck_rise & (state_q == ST_CAP_DR);
  assign shift_dr_en = tck_rise & (state_q == ST_SHIFT_DR);

  // ==========================================================================
  // instruction register: shift stage and active stage
  logic [IR_WIDTH-1:0] ir_shift;
  logic [IR_WIDTH-1:0] ir_act_q;
  logic [IR_WIDTH-1:0] ir_act_d;

  srtap_scan_reg #(.WIDTH(IR_WIDTH)) u_ir (
    .clk        (core_clk),
    .rst        (rst),
    .capture_en (cap_ir_en),
    .shift_en   (shift_ir_en),
    .cap_val    (IR_CAPTURE_VAL),
    .scan_in    (tdi_s),
    .data       (ir_shift)
  );

  // reset state forces identification; otherwise only Update-IR loads
  assign ir_act_d = (state_q == ST_RESET) ? INSTR_IDCODE :
                    (upd_ir_en ? ir_shift : ir_act_q);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ir_act_q <= INSTR_IDCODE;
    end else begin
      ir_act_q <= ir_act_d;
    end
  end

  // ==========================================================================
  // instruction decode; reserved codes fall through to bypass
  logic dec_ext;
  logic dec_id;
  logic dec_sampz;
  logic dec_samp;
  logic sel_bsr;
  logic sel_id;
  logic sel_byp;
  logic hiz_d;
  assign dec_ext   = (ir_act_q == INSTR_EXTEST);
  assign dec_id    = (ir_act_q == INSTR_IDCODE);
  assign dec_sampz = (ir_act_q == INSTR_SAMPLE_Z);
  assign dec_samp  = (ir_act_q == INSTR_SAMPLE);
  assign sel_bsr   = dec_ext | dec_sampz | dec_samp;
  assign sel_id    = dec_id;
  assign sel_byp   = ~sel_bsr & ~sel_id;
  assign hiz_d     = dec_ext | dec_sampz;

  // ==========================================================================
  // data registers; no update stage exists, so Update-DR acts as Pause-DR
  logic [0:0]          byp_data;
  logic [ID_WIDTH-1:0] id_data;
  logic [BSR_W-1:0]    bsr_data;

  srtap_scan_reg #(.WIDTH(1)) u_bypass (
    .clk        (core_clk),
    .rst        (rst),
    .capture_en (cap_dr_en & sel_byp),
    .shift_en   (shift_dr_en & sel_byp),
    .cap_val    (BYPASS_CAP_VAL),
    .scan_in    (tdi_s),
    .data       (byp_data)
  );

  srtap_scan_reg #(.WIDTH(ID_WIDTH)) u_idreg (
    .clk        (core_clk),
    .rst        (rst),
    .capture_en (cap_dr_en & sel_id),
    .shift_en   (shift_dr_en & sel_id),
    .cap_val    (ID_CODE),
    .scan_in    (tdi_s),
    .data       (id_data)
  );

  // capture only: contents never reach a pin or the memory core
  srtap_scan_reg #(.WIDTH(BSR_W)) u_bsr (
    .clk        (core_clk),
    .rst        (rst),
    .capture_en (cap_dr_en & sel_bsr),
    .shift_en   (shift_dr_en & sel_bsr),
    .cap_val    (ring_s),
    .scan_in    (tdi_s),
    .data       (bsr_data)
  );

  // ==========================================================================
  // TDO selection, registered on the falling test clock edge
  logic in_shift;
  logic dr_lsb;
  logic tdo_d;
  logic tdo_q;
  logic tdo_oe_q;
  logic hiz_q;
  assign in_shift = (state_q == ST_SHIFT_IR) | (state_q == ST_SHIFT_DR);
  assign dr_lsb   = sel_bsr ? bsr_data[0] : (sel_id ? id_data[0] : byp_data[0]);
  assign tdo_d    = (state_q == ST_SHIFT_IR) ? ir_shift[0] : dr_lsb;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q    <= tdo_d;
      tdo_oe_q <= in_shift;
    end
  end

  // output driver disable follows the active instruction
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hiz_q <= 1'b0;
    end else begin
      hiz_q <= hiz_d;
    end
  end

  assign tdo_out      = tdo_q;
  assign tdo_oe       = tdo_oe_q;
  assign sram_out_hiz = hiz_q;

  // ==========================================================================
  // checks
  // run of TMS-high rises, saturating at the reset count
  localparam logic [2:0] TMS_RUN_TOP = 3'(RESET_TMS_RISES);
  logic [2:0]            tms_run_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tms_run_q <= 3'h0;
    end else if (tck_rise) begin
      tms_run_q <= !tms_s ? 3'h0 : ((tms_run_q == TMS_RUN_TOP) ? tms_run_q : tms_run_q + 3'h1);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_tlr_loads_id: assert property (
    state_q == ST_RESET |=> ir_act_q == INSTR_IDCODE)
    else $error("identification not current after test-logic-reset");
  a_capture_ir_pat: assert property (
    cap_ir_en |=> ir_shift[1:0] == 2'b01)
    else $error("Capture-IR did not load 01");
  a_update_ir_apply: assert property (
    upd_ir_en |=> ir_act_q == $past(ir_shift))
    else $error("Update-IR did not apply shifted instruction");
  a_ir_hold: assert property (
    !upd_ir_en && state_q != ST_RESET |=> $stable(ir_act_q))
    else $error("instruction changed outside Update-IR");
  a_hiz_decode: assert property (
    ##1 sram_out_hiz == ($past(ir_act_q) == INSTR_EXTEST || $past(ir_act_q) == INSTR_SAMPLE_Z))
    else $error("output high-Z does not follow instruction");
  a_tdo_oe_shift: assert property (
    tck_fall |=> tdo_oe == $past(in_shift))
    else $error("TDO enable outside shift states");
  a_tdo_fall_only: assert property (
    !tck_fall |=> $stable(tdo_out) && $stable(tdo_oe))
    else $error("TDO changed without falling test clock");
  a_bypass_path: assert property (
    tck_fall && state_q == ST_SHIFT_DR && sel_byp |=> tdo_out == $past(byp_data[0]))
    else $error("bypass bit not on TDO");
  a_reset_five: assert property (
    tms_run_q == TMS_RUN_TOP |-> state_q == ST_RESET)
    else $error("five TMS-high rises did not reset");
  a_id_capture: assert property (
    cap_dr_en && sel_id |=> id_data == ID_CODE)
    else $error("identification code not captured");
  a_bsr_capture: assert property (
    cap_dr_en && sel_bsr |=> bsr_data == $past(ring_s))
    else $error("boundary register missed ring snapshot");

  c_id_shift: cover property (shift_dr_en && sel_id);
  c_update_ir: cover property (upd_ir_en ##1 dec_sampz);
  c_ext_hiz: cover property (dec_ext ##1 sram_out_hiz);
  c_bypass_shift: cover property (shift_dr_en && sel_byp);

endmodule // srtap_top

`default_nettype wire

// ### verification/sram_tap_instruction_logic_test.sv
/*
  Self-checking bench for the SRAM test access port instruction logic.
  Assumes srtap_pkg and srtap_ctrl_model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module sram_tap_instruction_logic_test;
  import srtap_pkg::*;
  localparam int          BW  = BSR_WIDTH;
  localparam logic [31:0] IDV = 32'h1234_5679; // arbitrary value, bit 0 set

  // ==========================================================================
  // signals
  logic          core_clk;
  logic          rst;
  logic          tck;
  logic          tms;
  logic          tdi;
  logic          tdo_out;
  logic          tdo_oe;
  logic [BW-1:0] io_ring;
  logic          sram_out_hiz;
  logic          bit_stb;
  logic          bit_oe;
  logic          bit_val;
  int            num_errors  = 0;
  int            comparisons = 0;
  integer        seed        = 32'h5b93_835d;
  // note: [2] data checked, [1] expected enable, [0] expected data
  logic [2:0]    notes[$];
  logic [2:0]    nt;

  srtap_ctrl_model ctl (
    .core_clk (core_clk),
    .tck      (tck),
    .tms      (tms),
    .tdi      (tdi),
    .tdo_out  (tdo_out),
    .tdo_oe   (tdo_oe),
    .bit_stb  (bit_stb),
    .bit_oe   (bit_oe),
    .bit_val  (bit_val)
  );

  srtap_top #(.BSR_W(BW), .ID_CODE(IDV)) uut (
    .core_clk     (core_clk),
    .rst          (rst),
    .tck          (tck),
    .tms          (tms),
    .tdi          (tdi),
    .tdo_out      (tdo_out),
    .tdo_oe       (tdo_oe),
    .io_ring      (io_ring),
    .sram_out_hiz (sram_out_hiz)
  );

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ==========================================================================
  // reporting
  task automatic fail(input string msg);
    num_errors++;
    $display("FAIL %0t: %s", $time, msg);
  endtask

  task automatic check(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) fail(msg);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // stimulus: every test clock leaves a note of what tdo must show
  task automatic tick(input logic m, input logic d, input logic [2:0] note);
    notes.push_back(note);
    ctl.step(m, d);
  endtask

  // full pass from idle through capture, shift and update back to idle
  task automatic scan(input logic ir, input int n, input logic [79:0] din,
                      input logic [79:0] dexp);
    tick(1'b1, 1'b1, 3'b000);
    if (ir) tick(1'b1, 1'b1, 3'b000);
    tick(1'b0, 1'b1, 3'b000);
    tick(1'b0, 1'b1, 3'b000);
    for (int i = 0; i < n; i++)
      tick(i == n - 1, din[i], {2'b11, dexp[i]});
    tick(1'b1, 1'b1, 3'b000);
    tick(1'b0, 1'b1, 3'b000);
  endtask

  // ==========================================================================
  // watcher: each tdo sample is matched against the oldest note
  always @(posedge core_clk) begin
    if (bit_stb) begin
      if (notes.size() == 0) begin
        fail("tdo sample with no note");
      end else begin
        nt = notes.pop_front();
        check(bit_oe, nt[1], "tdo enable");
        if (nt[2]) check(bit_val, nt[0], "tdo data");
      end
    end
  end

  // watchdog, well above the roughly 85 us that the sequence needs
  initial begin
    #2_000_000;
    fail("watchdog expired");
    end_of_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    logic [95:0] r;
    logic [79:0] din;
    logic [79:0] dexp;
    int          n;
    rst     = 1'b1;
    io_ring = '0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    check(tdo_oe, 1'b0, "tdo driven in reset");
    check(sram_out_hiz, 1'b0, "hiz set in reset");
    repeat (4) @(posedge core_clk);
    tick(1'b0, 1'b1, 3'b000);
    scan(1'b0, 32, 80'h0, 80'(IDV));
    // every legal code, with random ring and scan data; reserved codes never loaded
    for (int c = 0; c < 8; c++) begin
      if (c == 3 || c == 5 || c == 6) continue;
      r = {$random(seed), $random(seed), $random(seed)};
      din = r[95:16];
      // ring stands still through capture, clock bit too, so every bit is compared
      io_ring <= r[BW-1:0];
      scan(1'b1, 3, {77'h0, 3'(c)}, 80'(IR_CAPTURE_VAL));
      repeat (4) @(posedge core_clk);
      check(sram_out_hiz, c == 0 || c == 2, "hiz after load");
      case (c)
        1: begin
          n = 32;
          dexp = 80'(IDV);
        end
        0, 2, 4: begin
          n = BW;
          dexp = 80'(r[BW-1:0]);
        end
        default: begin
          n = 8;
          dexp = {din[78:0], BYPASS_CAP_VAL};
        end
      endcase
      scan(1'b0, n, din, dexp);
      check(sram_out_hiz, c == 0 || c == 2, "hiz after update");
    end
    // shift zeros into the instruction, then five tms-high clocks
    tick(1'b1, 1'b0, 3'b000);
    tick(1'b1, 1'b0, 3'b000);
    tick(1'b0, 1'b0, 3'b000);
    tick(1'b0, 1'b0, 3'b000);
    tick(1'b0, 1'b0, 3'b111);
    tick(1'b1, 1'b0, 3'b110);
    repeat (4) tick(1'b1, 1'b0, 3'b000);
    repeat (4) @(posedge core_clk);
    check(sram_out_hiz, 1'b0, "hiz after tms reset");
    tick(1'b0, 1'b1, 3'b000);
    scan(1'b0, 32, 80'h0, 80'(IDV));
    repeat (4) @(posedge core_clk);
    if (notes.size() != 0) fail("notes left over");
    end_of_test();
  end
endmodule // sram_tap_instruction_logic_test

`default_nettype wire

// ### verification/srtap_ctrl_model.sv
/*
  Behavioural boundary-scan test controller that steps the test pins.
  Assumes core_clk is only a timebase: one test clock lasts 8 core cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module srtap_ctrl_model (
  // timebase
  input  wire logic core_clk,
  // test pins
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  input  wire logic tdo_out,
  input  wire logic tdo_oe,
  // data out seen at each test clock, one pulse per clock
  output var  logic bit_stb,
  output var  logic bit_oe,
  output var  logic bit_val
);
  // ==========================================================================
  // released tdo has no pull, so show the inverse of the last driven bit
  logic tdo_last;
  logic tdo_wire;

  assign tdo_wire = tdo_oe ? tdo_out : ~tdo_last;

  // test clock stands low between steps
  initial begin
    tck      = 1'b0;
    tms      = 1'b1;
    tdi      = 1'b1;
    bit_stb  = 1'b0;
    bit_oe   = 1'b0;
    bit_val  = 1'b0;
    tdo_last = 1'b0;
  end

  // remember the last driven level of tdo
  always @(posedge core_clk) begin
    if (tdo_oe) begin
      tdo_last <= tdo_out;
    end
  end

  // ==========================================================================
  // one test clock, 200 ns: tms/tdi settle in the low half, tdo read late
  // in the high half so a slow tdo update after the fall is never raced
  task automatic step(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge core_clk);
    tck <= 1'b1;
    repeat (3) @(posedge core_clk);
    bit_oe  <= tdo_oe;
    bit_val <= tdo_wire;
    bit_stb <= 1'b1;
    @(posedge core_clk);
    bit_stb <= 1'b0;
    tck     <= 1'b0;
  endtask
endmodule // srtap_ctrl_model

`default_nettype wire
